//--- include/adc_seq_pkg.sv
// Shared constants, register map and carrier types of the conversion sequencer.
package adc_seq_pkg;

   // ==========================================================
   // Register byte offsets on the APB slave.
   localparam logic [7:0] OFF_CTL_A = 8'h00; // Control A.
   localparam logic [7:0] OFF_CTL_B = 8'h04; // Control B.
   localparam logic [7:0] OFF_DELAY = 8'h08; // Start delay count.
   localparam logic [7:0] OFF_RES_H = 8'h0C; // Result high byte.
   localparam logic [7:0] OFF_RES_L = 8'h10; // Result low byte.
   localparam logic [7:0] OFF_LOW_H = 8'h14; // Lower limit high byte.
   localparam logic [7:0] OFF_LOW_L = 8'h18; // Lower limit low byte.
   localparam logic [7:0] OFF_UPP_H = 8'h1C; // Upper limit high byte.
   localparam logic [7:0] OFF_UPP_L = 8'h20; // Upper limit low byte.
   localparam logic [7:0] OFF_IRQ_ST = 8'h24; // Sticky status, read only.
   localparam logic [7:0] OFF_IRQ_CLR = 8'h28; // Write one to clear.
   localparam logic [7:0] OFF_IRQ_EN = 8'h2C; // Per-source enables.
   localparam logic [7:0] OFF_IRQ_GLB = 8'h30; // Global and group enables.

   // ==========================================================
   // Field positions of the interrupt registers.
   localparam int unsigned IRQ_DONE = 0; // End of conversion.
   localparam int unsigned IRQ_LIMIT = 1; // Boundary compare hit.
   localparam int unsigned IRQ_CZERO = 2; // Comparator zero event.
   localparam int unsigned IRQ_W = 3; // Number of sources.
   localparam int unsigned GLB_EN = 0; // Global enable bit.
   localparam int unsigned GRP_EN = 1; // Multi-function group enable bit.

   // ==========================================================
   // Reset values and timing.
   localparam logic [7:0] CTL_A_RST = 8'h60; // Busy and power-off set.
   localparam logic [7:0] CTL_B_RST = 8'h00; // All clear.
   localparam logic [3:0] CONV_LAST = 4'hF; // Sixteenth converter clock.
   localparam logic [2:0] DIV_UNDEF = 3'h7; // Undefined divider code.
   localparam logic [3:0] CH_OPAMP = 4'h6; // Op-amp output channel.
   localparam logic [3:0] CH_LAST = 4'h8; // Highest defined channel.
   localparam logic [3:0] CH_GAP_LO = 4'h4; // First undefined code.
   localparam logic [3:0] CH_GAP_HI = 4'h5; // Second undefined code.

   // Control A register layout.
   typedef struct packed {
      logic soft_start_bit;
      logic conv_busy_flag;
      logic conv_power_off;
      logic result_align_sel;
      logic [3:0] input_channel_sel;
   } ctl_a_s;

   // Control B register layout; bit 5 is stored for software only.
   typedef struct packed {
      logic trigger_source_sel;
      logic delayed_start_enable;
      logic pwm_event_sel;
      logic upper_compare_mode;
      logic lower_compare_mode;
      logic [2:0] conv_clock_div_sel;
   } ctl_b_s;

   // Sequencer states, one-hot.
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_HOLD = 4'h2,
      ST_DELAY = 4'h4,
      ST_CONV = 4'h8
   } seq_state_e;

endpackage : adc_seq_pkg

//--- src/conv_clock_divider.sv
// Converter clock enable divider with power-of-two ratios.
`timescale 1ns/100ps
`default_nettype none

module conv_clock_divider (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clear,
   input wire logic [2:0] div_sel,
   output logic tick
);

   // ==========================================================
   // Divider counter.
   logic [5:0] cnt_r; // Cycles since last tick.
   logic [5:0] lim; // Terminal count for the ratio.

   // The undefined code runs at the slowest ratio, keeping it safe.
   always_comb begin
      if (div_sel == adc_seq_pkg::DIV_UNDEF) begin
         lim = 6'h3F;
      end else begin
         lim = 6'((7'h01 << div_sel) - 7'h01);
      end
   end

   // One pulse every 2^sel cycles, 64 for code 7; a clear aligns the phase to a start.
   assign tick = (cnt_r == lim);

   // Counter restarts on clear so a conversion is exact in length.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 6'h00;
      end else if (clear || tick) begin
         cnt_r <= 6'h00;
      end else begin
         cnt_r <= cnt_r + 6'h01;
      end
   end

endmodule : conv_clock_divider

`default_nettype wire

//--- src/adc_conversion_sequencer.sv
// Conversion sequencer with APB registers, limit compare and interrupts.
// How it works
// - Converter clock is system clock over 1..64.
// - Converts only while power-off bit is zero.
// - Compare result to boundaries; flag limit interrupt.
// - A conversion lasts sixteen converter clocks.
// - Start bit pulse zero-one-zero starts conversion.
// - Busy high during conversion, low with result.
// - Done interrupt needs global, own, group enables.
// - One bit selects software or PWM trigger.
// - One bit selects byte split of values.
// - Channel field routes input to converter.
// - Results are unsigned twelve-bit, full scale FFF.
// - Limit and comparator-zero are separate interrupts.
// - Align zero: high 11:4; one: high 11:8.
// - Channel codes map to inputs, others undefined.
// - Start bit held high resets, holds busy.
// - Delay equals count times system clock period.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module adc_conversion_sequencer #(
   parameter int unsigned RES_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pwm_trigger,
   input wire logic comparator_event,
   input wire logic [RES_W-1:0] sar_result,
   output logic conv_power_on,
   output logic conv_reset,
   output logic conv_start,
   output logic [3:0] conv_channel,
   output logic conv_channel_valid,
   output logic limit_compare_irq,
   output logic comparator_zero_irq,
   output logic irq
);

   // ==========================================================
   // Helpers.

   // Splits a value into its high byte per the alignment bit.
   function automatic logic [7:0] hi_byte(input logic [11:0] v,
                                          input logic al);
      hi_byte = al ? {4'h0, v[11:8]} : v[11:4];
   endfunction : hi_byte

   // Splits a value into its low byte per the alignment bit.
   function automatic logic [7:0] lo_byte(input logic [11:0] v,
                                          input logic al);
      lo_byte = al ? v[7:0] : {v[3:0], 4'h0};
   endfunction : lo_byte

   // Joins a boundary byte pair back into twelve bits.
   function automatic logic [11:0] join12(input logic [7:0] h,
                                          input logic [7:0] l,
                                          input logic al);
      join12 = al ? {h[3:0], l} : {h, l[7:4]};
   endfunction : join12

   // ==========================================================
   // Register state.
   adc_seq_pkg::ctl_a_s ctl_a_r; // Control A; busy bit unused here.
   adc_seq_pkg::ctl_b_s ctl_b_r; // Control B.
   logic [7:0] start_delay_count; // Delay in system clocks.
   logic [7:0] lower_limit_high_byte;
   logic [7:0] lower_limit_low_byte;
   logic [7:0] upper_limit_high_byte;
   logic [7:0] upper_limit_low_byte;
   logic [11:0] result_r; // Last valid conversion value.
   logic conv_busy_flag; // Read-only busy flag.
   logic [adc_seq_pkg::IRQ_W-1:0] irq_st_r; // Sticky status.
   logic [adc_seq_pkg::IRQ_W-1:0] irq_en_r; // Source enables.
   logic [1:0] irq_glb_r; // Global and group enables.
   logic [31:0] prdata_r; // Read data captured in setup.

   // Sequencer state.
   adc_seq_pkg::seq_state_e state_r;
   adc_seq_pkg::seq_state_e state_nxt;
   logic [7:0] dly_r; // Remaining delay cycles.
   logic [3:0] tick_cnt_r; // Converter clocks done so far.
   logic [2:0] div_sel_r; // Ratio frozen for a conversion.
   logic tick; // Converter clock enable.
   logic powered; // Converter powered.
   logic done; // Last cycle of a conversion.
   logic pwm_take; // PWM trigger accepted.
   logic soft_sel; // Software trigger selected.
   logic limit_hit; // Boundary condition met.
   logic [11:0] low_lim; // Lower boundary.
   logic [11:0] upp_lim; // Upper boundary.
   logic gl_en; // Global interrupt enable.

   // ==========================================================
   // APB decode. Zero wait states; unmapped access answers an error.
   logic wr; // Write takes effect this edge.
   logic rd_setup; // Read setup phase.
   logic addr_ok; // Address is mapped.
   logic [adc_seq_pkg::IRQ_W-1:0] clr_w; // Status bits to clear.

   always_comb begin
      case (paddr)
         adc_seq_pkg::OFF_CTL_A, adc_seq_pkg::OFF_CTL_B,
         adc_seq_pkg::OFF_DELAY, adc_seq_pkg::OFF_RES_H,
         adc_seq_pkg::OFF_RES_L, adc_seq_pkg::OFF_LOW_H,
         adc_seq_pkg::OFF_LOW_L, adc_seq_pkg::OFF_UPP_H,
         adc_seq_pkg::OFF_UPP_L, adc_seq_pkg::OFF_IRQ_ST,
         adc_seq_pkg::OFF_IRQ_CLR, adc_seq_pkg::OFF_IRQ_EN,
         adc_seq_pkg::OFF_IRQ_GLB: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   assign wr = psel && penable && pwrite && addr_ok;
   assign rd_setup = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok;
   assign prdata = prdata_r;
   assign clr_w = (wr && paddr == adc_seq_pkg::OFF_IRQ_CLR) ?
                  pwdata[adc_seq_pkg::IRQ_W-1:0] : '0;

   // Read data is latched in the setup cycle so it leaves a flip-flop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata_r <= 32'h0000_0000;
         case (paddr)
            adc_seq_pkg::OFF_CTL_A: prdata_r[7:0] <= {ctl_a_r[7],
               conv_busy_flag, ctl_a_r[5:0]};
            adc_seq_pkg::OFF_CTL_B: prdata_r[7:0] <= ctl_b_r;
            adc_seq_pkg::OFF_DELAY: prdata_r[7:0] <= start_delay_count;
            adc_seq_pkg::OFF_RES_H: prdata_r[7:0] <=
               hi_byte(result_r, ctl_a_r.result_align_sel);
            adc_seq_pkg::OFF_RES_L: prdata_r[7:0] <=
               lo_byte(result_r, ctl_a_r.result_align_sel);
            adc_seq_pkg::OFF_LOW_H: prdata_r[7:0] <= lower_limit_high_byte;
            adc_seq_pkg::OFF_LOW_L: prdata_r[7:0] <= lower_limit_low_byte;
            adc_seq_pkg::OFF_UPP_H: prdata_r[7:0] <= upper_limit_high_byte;
            adc_seq_pkg::OFF_UPP_L: prdata_r[7:0] <= upper_limit_low_byte;
            adc_seq_pkg::OFF_IRQ_ST:
               prdata_r[adc_seq_pkg::IRQ_W-1:0] <= irq_st_r;
            adc_seq_pkg::OFF_IRQ_EN:
               prdata_r[adc_seq_pkg::IRQ_W-1:0] <= irq_en_r;
            adc_seq_pkg::OFF_IRQ_GLB: prdata_r[1:0] <= irq_glb_r;
            default: prdata_r <= 32'h0000_0000;
         endcase
      end
   end

   // Software-written configuration registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_a_r <= adc_seq_pkg::CTL_A_RST;
         ctl_b_r <= adc_seq_pkg::CTL_B_RST;
         start_delay_count <= 8'h00;
         lower_limit_high_byte <= 8'h00;
         lower_limit_low_byte <= 8'h00;
         upper_limit_high_byte <= 8'h00;
         upper_limit_low_byte <= 8'h00;
         irq_en_r <= '0;
         irq_glb_r <= 2'h0;
      end else if (wr) begin
         case (paddr)
            adc_seq_pkg::OFF_CTL_A: ctl_a_r <= pwdata[7:0];
            adc_seq_pkg::OFF_CTL_B: ctl_b_r <= pwdata[7:0];
            adc_seq_pkg::OFF_DELAY: start_delay_count <= pwdata[7:0];
            adc_seq_pkg::OFF_LOW_H: lower_limit_high_byte <= pwdata[7:0];
            adc_seq_pkg::OFF_LOW_L: lower_limit_low_byte <= pwdata[7:0];
            adc_seq_pkg::OFF_UPP_H: upper_limit_high_byte <= pwdata[7:0];
            adc_seq_pkg::OFF_UPP_L: upper_limit_low_byte <= pwdata[7:0];
            adc_seq_pkg::OFF_IRQ_EN:
               irq_en_r <= pwdata[adc_seq_pkg::IRQ_W-1:0];
            adc_seq_pkg::OFF_IRQ_GLB: irq_glb_r <= pwdata[1:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Converter clock, channel routing and power.
   assign powered = !ctl_a_r.conv_power_off;
   assign conv_power_on = powered;
   assign conv_channel = ctl_a_r.input_channel_sel;

   // Gap codes and codes above the last input are flagged undefined.
   assign conv_channel_valid = (conv_channel <= adc_seq_pkg::CH_LAST) &&
      (conv_channel != adc_seq_pkg::CH_GAP_LO) &&
      (conv_channel != adc_seq_pkg::CH_GAP_HI);

   conv_clock_divider u_div (
      .pclk(pclk),
      .presetn(presetn),
      .clear(conv_start),
      .div_sel(div_sel_r),
      .tick(tick)
   );

   // ==========================================================
   // Sequencer.
   assign soft_sel = !ctl_b_r.trigger_source_sel;
   assign pwm_take = powered && !soft_sel && pwm_trigger &&
                     state_r == adc_seq_pkg::ST_IDLE;
   // Gated by power, so an abort on the last tick keeps the old result.
   assign done = powered && state_r == adc_seq_pkg::ST_CONV && tick &&
                 tick_cnt_r == adc_seq_pkg::CONV_LAST;
   assign conv_start = state_r != adc_seq_pkg::ST_CONV &&
                       state_nxt == adc_seq_pkg::ST_CONV;
   assign conv_reset = state_r == adc_seq_pkg::ST_HOLD;

   // With the software trigger selected, a high start bit wins over everything but power-off and parks the converter.
   always_comb begin
      state_nxt = state_r;
      if (!powered) begin
         state_nxt = adc_seq_pkg::ST_IDLE;
      end else if (soft_sel && ctl_a_r.soft_start_bit) begin
         state_nxt = adc_seq_pkg::ST_HOLD;
      end else begin
         case (state_r)
            adc_seq_pkg::ST_IDLE: begin
               if (pwm_take) begin
                  // A zero count means start at once.
                  if (ctl_b_r.delayed_start_enable &&
                      start_delay_count != 8'h00) begin
                     state_nxt = adc_seq_pkg::ST_DELAY;
                  end else begin
                     state_nxt = adc_seq_pkg::ST_CONV;
                  end
               end
            end
            adc_seq_pkg::ST_HOLD: begin
               // Falling start bit completes the pulse.
               state_nxt = soft_sel ? adc_seq_pkg::ST_CONV :
                           adc_seq_pkg::ST_IDLE;
            end
            adc_seq_pkg::ST_DELAY: begin
               if (dly_r == 8'h01) begin
                  state_nxt = adc_seq_pkg::ST_CONV;
               end
            end
            adc_seq_pkg::ST_CONV: begin
               if (done) begin
                  state_nxt = adc_seq_pkg::ST_IDLE;
               end
            end
            default: state_nxt = adc_seq_pkg::ST_IDLE;
         endcase
      end
   end

   // State, delay and converter clock counters.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= adc_seq_pkg::ST_IDLE;
         dly_r <= 8'h00;
         tick_cnt_r <= 4'h0;
         div_sel_r <= 3'h0;
      end else begin
         state_r <= state_nxt;
         if (pwm_take) begin
            dly_r <= start_delay_count;
         end else if (state_r == adc_seq_pkg::ST_DELAY) begin
            dly_r <= dly_r - 8'h01;
         end
         if (conv_start) begin
            tick_cnt_r <= 4'h0;
            div_sel_r <= ctl_b_r.conv_clock_div_sel;
         end else if (state_r == adc_seq_pkg::ST_CONV && tick) begin
            tick_cnt_r <= tick_cnt_r + 4'h1;
         end
      end
   end

   // Busy rises on hold or start; falls with the result load.
   // It resets high and stays so until a first conversion ends or a power-off aborts a hold, delay or conversion.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_busy_flag <= 1'b1;
         result_r <= 12'h000;
      end else if (done) begin
         conv_busy_flag <= 1'b0;
         result_r <= sar_result[11:0];
      end else if (state_nxt == adc_seq_pkg::ST_HOLD || conv_start) begin
         conv_busy_flag <= 1'b1;
      end else if (!powered && state_r != adc_seq_pkg::ST_IDLE) begin
         conv_busy_flag <= 1'b0;
      end
   end

   // ==========================================================
   // Boundary compare on the fresh result.
   assign low_lim = join12(lower_limit_high_byte, lower_limit_low_byte,
                           ctl_a_r.result_align_sel);
   assign upp_lim = join12(upper_limit_high_byte, upper_limit_low_byte,
                           ctl_a_r.result_align_sel);

   always_comb begin
      case ({ctl_b_r.upper_compare_mode, ctl_b_r.lower_compare_mode})
         2'h0: limit_hit = sar_result >= low_lim && sar_result <= upp_lim;
         2'h1: limit_hit = sar_result < low_lim;
         2'h2: limit_hit = sar_result > upp_lim;
         default: limit_hit = sar_result < low_lim || sar_result > upp_lim;
      endcase
   end

   // ==========================================================
   // Interrupts. A set in the same cycle as a clear wins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_st_r <= '0;
      end else begin
         irq_st_r[adc_seq_pkg::IRQ_DONE] <= done ||
            (irq_st_r[adc_seq_pkg::IRQ_DONE] &&
             !clr_w[adc_seq_pkg::IRQ_DONE]);
         irq_st_r[adc_seq_pkg::IRQ_LIMIT] <= (done && limit_hit) ||
            (irq_st_r[adc_seq_pkg::IRQ_LIMIT] &&
             !clr_w[adc_seq_pkg::IRQ_LIMIT]);
         irq_st_r[adc_seq_pkg::IRQ_CZERO] <= comparator_event ||
            (irq_st_r[adc_seq_pkg::IRQ_CZERO] &&
             !clr_w[adc_seq_pkg::IRQ_CZERO]);
      end
   end

   assign gl_en = irq_glb_r[adc_seq_pkg::GLB_EN];
   assign limit_compare_irq = gl_en && irq_st_r[adc_seq_pkg::IRQ_LIMIT] &&
                              irq_en_r[adc_seq_pkg::IRQ_LIMIT];
   assign comparator_zero_irq = gl_en && irq_st_r[adc_seq_pkg::IRQ_CZERO] &&
                                irq_en_r[adc_seq_pkg::IRQ_CZERO];
   assign irq = limit_compare_irq || comparator_zero_irq ||
                (gl_en && irq_glb_r[adc_seq_pkg::GRP_EN] &&
                 irq_st_r[adc_seq_pkg::IRQ_DONE] &&
                 irq_en_r[adc_seq_pkg::IRQ_DONE]);

   // ==========================================================
   // Checks.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   int unsigned conv_cyc; // Cycles spent converting.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_cyc <= 0;
      end else begin
         conv_cyc <= conv_start ? 0 : conv_cyc + 1;
      end
   end

   sequence hold_s;
      state_r == adc_seq_pkg::ST_HOLD && ctl_a_r.soft_start_bit;
   endsequence
   sequence release_s;
      !ctl_a_r.soft_start_bit && powered && soft_sel;
   endsequence

   done_coincide_a: assert property (done |=> !conv_busy_flag &&
      irq_st_r[adc_seq_pkg::IRQ_DONE] && result_r == $past(sar_result))
      else $error("done did not update busy, flag and result together");
   conv_length_a: assert property (done |->
      conv_cyc == ((16 << (div_sel_r == 3'h7 ? 6 : div_sel_r)) - 1))
      else $error("conversion length is not sixteen converter clocks");
   hold_busy_a: assert property (hold_s |=> conv_busy_flag)
      else $error("busy not high while start bit held");
   soft_start_a: assert property (hold_s ##1 release_s |=>
      state_r == adc_seq_pkg::ST_CONV)
      else $error("start pulse did not begin a conversion");
   off_ignore_a: assert property (!powered |=>
      $stable(result_r) && state_r == adc_seq_pkg::ST_IDLE)
      else $error("powered-off converter changed state or result");
   delay_load_a: assert property (pwm_take &&
      ctl_b_r.delayed_start_enable && start_delay_count != 8'h00 |=>
      state_r == adc_seq_pkg::ST_DELAY && dly_r == $past(start_delay_count))
      else $error("delayed start did not load the count");
   irq_gate_a: assert property (!gl_en ||
      (!irq_glb_r[adc_seq_pkg::GRP_EN] && !limit_compare_irq &&
       !comparator_zero_irq) |-> !irq)
      else $error("interrupt raised without its enables");
   limit_flag_a: assert property (done && limit_hit |=>
      irq_st_r[adc_seq_pkg::IRQ_LIMIT])
      else $error("boundary hit did not set the limit flag");

endmodule : adc_conversion_sequencer

`default_nettype wire

//--- dv/sar_model.sv
// Behavioural model of the analog converter facing the sequencer.
`timescale 1ns/100ps
`default_nettype none

module sar_model (
   input wire logic pclk,
   input wire logic conv_power_on,
   input wire logic [3:0] conv_channel,
   output logic [11:0] sar_result
);
   // ==========================================================
   // Result source
   // The routed channel lands in the top nibble, so a wrong route shows.
   // Powered off the code toggles every cycle; a stale capture then shows.
   initial sar_result = 12'h000;
   always @(posedge pclk) begin
      if (conv_power_on) begin
         sar_result <= {conv_channel, 8'hA5};
      end else begin
         sar_result <= ~sar_result;
      end
   end
endmodule : sar_model
`default_nettype wire

//--- dv/tb_adc_conversion_sequencer.sv
// Self-checking bench of the conversion sequencer.
`timescale 1ns/100ps
`default_nettype none
`define chk(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
   $display("Error %s exp %h got %h", nm, e, g); n_fail++; end end

module tb_adc_conversion_sequencer;
   logic pclk, presetn, psel, penable, pwrite, pwm_trigger; // Stimulus.
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, err, conv_start, conv_reset, irq, lim_irq, pwr_on;
   logic cmp_ev, cz_irq, ch_ok; // Comparator event, its interrupt and the channel-valid flag.
   logic [11:0] sar_result;
   logic [3:0] chan;
   int n_fail = 0, n_checks = 0, cyc = 0, n;

   // ==========================================================
   // Design and converter model
   adc_conversion_sequencer dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pwm_trigger(pwm_trigger),
      .comparator_event(cmp_ev), .sar_result(sar_result),
      .conv_power_on(pwr_on), .conv_reset(conv_reset),
      .conv_start(conv_start), .conv_channel(chan),
      .conv_channel_valid(ch_ok), .limit_compare_irq(lim_irq),
      .comparator_zero_irq(cz_irq), .irq(irq));
   sar_model far (.pclk(pclk), .conv_power_on(pwr_on),
      .conv_channel(chan), .sar_result(sar_result));

   // ==========================================================
   // Clock, timeout and verdict
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         summarize();
      end
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : summarize

   // ==========================================================
   // APB master: request held until pready is seen at a rising edge.
   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the bench timeout ends a wait for the answer.
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Polls the busy flag; bounded so a stuck flag cannot hang the run.
   task automatic wait_idle();
      int t;
      t = 0;
      do begin
         apb(1'b0, adc_seq_pkg::OFF_CTL_A, 32'h0);
         t++;
      end while (rd[6] !== 1'b0 && t < 100);
      `chk("idle", 1'b0, rd[6])
   endtask : wait_idle
   // Start bit driven zero, one, zero as software must do.
   // The held state shows one edge after the write lands.
   task automatic soft_start(input logic [7:0] c);
      apb(1'b1, adc_seq_pkg::OFF_CTL_A, {24'h0, c | 8'h80});
      @(posedge pclk);
      #1;
      `chk("conv_reset", 1'b1, conv_reset)
      `chk("held start", 1'b0, conv_start)
      apb(1'b1, adc_seq_pkg::OFF_CTL_A, {24'h0, c});
      #1;
      `chk("conv_start", 1'b1, conv_start)
   endtask : soft_start

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      apb(1'b0, adc_seq_pkg::OFF_CTL_A, 32'h0);
      `chk("ctl_a reset", 32'h60, rd)
      apb(1'b0, 8'h34, 32'h0);
      `chk("unmapped", 1'b1, err)
   endtask : t_reset
   task automatic t_soft();
      apb(1'b1, adc_seq_pkg::OFF_IRQ_EN, 32'h7);
      apb(1'b1, adc_seq_pkg::OFF_IRQ_GLB, 32'h1);
      soft_start(8'h01);
      `chk("chan valid", 1'b1, ch_ok)
      wait_idle();
      apb(1'b0, adc_seq_pkg::OFF_RES_H, 32'h0);
      `chk("res_h align0", 32'h1A, rd)
      apb(1'b0, adc_seq_pkg::OFF_RES_L, 32'h0);
      `chk("res_l align0", 32'h50, rd)
      `chk("irq no group", 1'b0, irq)
      `chk("limit in range", 1'b0, lim_irq)
      apb(1'b0, adc_seq_pkg::OFF_IRQ_ST, 32'h0);
      `chk("status", 32'h1, rd)
      apb(1'b1, adc_seq_pkg::OFF_IRQ_GLB, 32'h3);
      #1;
      `chk("irq all on", 1'b1, irq)
      apb(1'b1, adc_seq_pkg::OFF_IRQ_CLR, 32'h1);
      #1;
      `chk("irq cleared", 1'b0, irq)
      // One comparator pulse; cleared again so later polls start quiet.
      @(posedge pclk);
      cmp_ev <= 1'b1;
      @(posedge pclk);
      cmp_ev <= 1'b0;
      #1;
      `chk("czero irq", 1'b1, cz_irq)
      apb(1'b1, adc_seq_pkg::OFF_IRQ_CLR, 32'h4);
      #1;
      `chk("czero clear", 1'b0, cz_irq)
   endtask : t_soft
   task automatic t_timed();
      apb(1'b1, adc_seq_pkg::OFF_LOW_H, 32'h2);
      apb(1'b1, adc_seq_pkg::OFF_CTL_B, 32'h09);
      soft_start(8'h11);
      n = 0;
      while (irq !== 1'b1 && n < 100) begin
         @(posedge pclk);
         #1;
         n++;
      end
      `chk("conv cycles", 33, n)
      `chk("limit below", 1'b1, lim_irq)
      apb(1'b0, adc_seq_pkg::OFF_RES_H, 32'h0);
      `chk("res_h align1", 32'h01, rd)
      apb(1'b0, adc_seq_pkg::OFF_RES_L, 32'h0);
      `chk("res_l align1", 32'hA5, rd)
   endtask : t_timed
   task automatic t_off();
      apb(1'b1, adc_seq_pkg::OFF_IRQ_CLR, 32'h3);
      apb(1'b1, adc_seq_pkg::OFF_CTL_A, 32'hB1);
      apb(1'b1, adc_seq_pkg::OFF_CTL_A, 32'h31);
      #1;
      `chk("off start", 1'b0, conv_start)
      `chk("power off", 1'b0, pwr_on)
      repeat (40) @(posedge pclk);
      apb(1'b0, adc_seq_pkg::OFF_RES_L, 32'h0);
      `chk("off result", 32'hA5, rd)
      apb(1'b1, adc_seq_pkg::OFF_CTL_A, 32'h35);
      #1;
      `chk("chan undef", 1'b0, ch_ok)
   endtask : t_off
   task automatic t_pwm();
      apb(1'b1, adc_seq_pkg::OFF_CTL_A, 32'h01);
      apb(1'b1, adc_seq_pkg::OFF_DELAY, 32'h5);
      apb(1'b1, adc_seq_pkg::OFF_CTL_B, 32'hC0);
      @(posedge pclk);
      pwm_trigger <= 1'b1;
      @(posedge pclk);
      pwm_trigger <= 1'b0;
      #1;
      n = 1;
      while (conv_start !== 1'b1 && n < 50) begin
         @(posedge pclk);
         #1;
         n++;
      end
      `chk("pwm delay", 5, n)
      wait_idle();
      apb(1'b0, adc_seq_pkg::OFF_IRQ_ST, 32'h0);
      `chk("pwm done", 1'b1, rd[0])
   endtask : t_pwm

   // ==========================================================
   // Main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pwm_trigger = 1'b0;
      cmp_ev = 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_soft();
      t_timed();
      t_off();
      t_pwm();
      summarize();
   end
endmodule : tb_adc_conversion_sequencer
`default_nettype wire
